// file: bench/pin_model.sv
`timescale 1ns/10ps
// Far-side driver on the shared channel pins
module pin_model (
	// Pin lines
	input  wire [5:0] ext_lvl,
	input  wire [5:0] pin_out,
	input  wire [5:0] pin_oe_n,
	output wire [5:0] pin_in
);
	// Pin level: design drives when enabled, else external level ext_lvl passes straight through
	assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule // pin_model

// file: bench/timer_channel_capture_compare_assertions.sv
`timescale 1ns/10ps
module tccc_checker (
	// Clock and reset
	input wire        core_clk,
	input wire        rst_n,
	// Register port
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	// Counter and pins
	input wire [15:0] counter_value,
	input wire        counter_overflow,
	input wire [5:0]  timer_channel_pin_out,
	input wire [5:0]  timer_channel_pin_oe_n,
	input wire [5:0]  channel_irq
);
	reg  [7:0] ctrl0_r;
	reg  [1:0] ovf_cnt_r;
	reg        wrote_r;
	wire       tov_on;
	assign tov_on = ctrl0_r[4] && ctrl0_r[3:2] != 2'h0 && ctrl0_r[1];
	// Shadow of channel 0 control and overflows since its last write
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_r <= 8'h00;
			ovf_cnt_r <= 2'h0;
			wrote_r <= 1'b0;
		end else begin
			wrote_r <= wrote_r | reg_wr;
			if (reg_wr && reg_addr == 8'h00) begin
				ctrl0_r <= reg_wdata;
				ovf_cnt_r <= 2'h0;
			end else if (counter_overflow && ovf_cnt_r != 2'h2) begin
				ovf_cnt_r <= ovf_cnt_r + 2'h1;
			end
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr_recent;
		$past(reg_wr) || $past(reg_wr, 2);
	endsequence
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_oe_cause; $changed(timer_channel_pin_oe_n) |-> s_wr_recent; endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
	property p_drive_ch0; $fell(timer_channel_pin_oe_n[0]) |-> ctrl0_r[3:2] != 2'h0; endproperty
	a_drive_ch0: assert property (p_drive_ch0) else $error("pin driven while off");
	property p_rst_oe; !wrote_r |-> timer_channel_pin_oe_n == 6'h3F; endproperty
	a_rst_oe: assert property (p_rst_oe) else $error("pin driven after reset");
	property p_rst_irq; !wrote_r |-> channel_irq == 6'h00; endproperty
	a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
	property p_irq_rise; $rose(channel_irq[0]) |-> ctrl0_r[6]; endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without enable");
	property p_irq_drop; $fell(channel_irq[0]) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3); endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq dropped alone");
	property p_ovf_toggle;
		counter_overflow && tov_on && !ctrl0_r[0] && !reg_wr |=> ##[0:1] $changed(timer_channel_pin_out[0]);
	endproperty
	a_ovf_toggle: assert property (p_ovf_toggle) else $error("no toggle on overflow");
	property p_max_hold;
		tov_on && ctrl0_r[0] && ovf_cnt_r == 2'h2 && !$past(counter_overflow) |-> timer_channel_pin_out[0];
	endproperty
	a_max_hold: assert property (p_max_hold) else $error("full duty lost");
endmodule // tccc_checker
bind timer_channel_capture_compare tccc_checker tccc_checker_inst (.core_clk, .rst_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .counter_value, .counter_overflow, .timer_channel_pin_out,
	.timer_channel_pin_oe_n, .channel_irq);

// file: bench/timer_channel_capture_compare_tb_top.sv
`timescale 1ns/10ps
module timer_channel_capture_compare_tb_top;
	reg         core_clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [7:0]  reg_addr = 8'h00;
	reg  [7:0]  reg_wdata = 8'h00;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [15:0] counter_value = 16'h8000;
	reg         counter_overflow = 1'b0;
	reg  [5:0]  ext_lvl = 6'h00;
	wire [7:0]  reg_rdata;
	wire [5:0]  pin_in, pin_out, pin_oe_n, channel_irq;
	integer     n_mismatch = 0, tests_run = 0, cycles = 0, i;
	reg  [7:0]  d;
	reg         p;
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
	end
	pin_model pin_model_inst (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
	timer_channel_capture_compare timer_channel_capture_compare_inst (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.counter_value(counter_value), .counter_overflow(counter_overflow), .timer_channel_pin_in(pin_in),
		.timer_channel_pin_out(pin_out), .timer_channel_pin_oe_n(pin_oe_n), .channel_irq(channel_irq));
	task check(input [7:0] seen, input [7:0] exp, input string what);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Counter event: compare value, overflow or both in one cycle
	task step(input [15:0] cv, input ovf);
		@(posedge core_clk);
		counter_value <= cv;
		counter_overflow <= ovf;
		@(posedge core_clk);
		counter_value <= 16'h8000;
		counter_overflow <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task set_pin(input lvl, input [15:0] cv);
		@(posedge core_clk);
		ext_lvl[4] <= lvl;
		counter_value <= cv;
		repeat (5) @(posedge core_clk);
	endtask
	task finish_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			rd(i * 4);
			check(d, 8'h00, "ctrl reset");
		end
		rd(8'h1B);
		check(d, 8'h00, "unmapped");
		wr(8'h00, 8'hD5);
		rd(8'h00);
		check(d, 8'h55, "ctrl write");
		wr(8'h04, 8'h54);
		wr(8'h00, 8'h00);
		check({7'h0, pin_oe_n[1]}, 8'h00, "odd driven");
		wr(8'h00, 8'h20);
		rd(8'h04);
		check(d, 8'h00, "odd ctrl");
		check({7'h0, pin_oe_n[1]}, 8'h01, "odd released");
		wr(8'h00, 8'h00);
		wr(8'h09, 8'hA5);
		wr(8'h0A, 8'h5A);
		rd(8'h09);
		check(d, 8'hA5, "value high");
		rd(8'h0A);
		check(d, 8'h5A, "value low");
		$display("test registers done");
		wr(8'h01, 8'h00);
		wr(8'h02, 8'h10);
		for (i = 3; i > 0; i = i - 1) begin
			wr(8'h00, {4'h1, i[1:0], 2'h0});
			step(16'h0010, 1'b0);
			check({7'h0, pin_out[0]}, {7'h0, i != 2}, "compare level");
		end
		wr(8'h00, 8'h54);
		@(posedge core_clk);
		#1;
		check({7'h0, channel_irq[0]}, 8'h01, "flag set");
		rd(8'h00);
		wr(8'h00, 8'h54);
		@(posedge core_clk);
		#1;
		check({7'h0, channel_irq[0]}, 8'h00, "flag clear");
		p = pin_out[0];
		wr(8'h01, 8'h00);
		step(16'h0010, 1'b0);
		check({7'h0, pin_out[0], channel_irq[0]}, {7'h0, p, 1'b0}, "half write");
		wr(8'h02, 8'h10);
		step(16'h0010, 1'b0);
		check({7'h0, pin_out[0], channel_irq[0]}, {7'h0, !p, 1'b1}, "full write");
		wr(8'h00, 8'h16);
		p = pin_out[0];
		step(16'h8000, 1'b1);
		check({7'h0, pin_out[0]}, {7'h0, !p}, "overflow toggle");
		step(16'h0010, 1'b1);
		check({7'h0, pin_out[0]}, {7'h0, p}, "overflow wins");
		wr(8'h00, 8'h17);
		step(16'h8000, 1'b1);
		step(16'h8000, 1'b1);
		step(16'h0010, 1'b0);
		check({7'h0, pin_out[0]}, 8'h01, "full duty");
		// Buffered pair: channel 2 first, channel 3 after the next overflow
		wr(8'h09, 8'h00);
		wr(8'h0A, 8'h10);
		wr(8'h0D, 8'h00);
		wr(8'h0E, 8'h20);
		wr(8'h08, 8'h24);
		step(16'h0020, 1'b0);
		check({7'h0, pin_out[2]}, 8'h01, "buffer idle");
		step(16'h0010, 1'b0);
		check({7'h0, pin_out[2]}, 8'h00, "buffer first");
		step(16'h8000, 1'b1);
		step(16'h0020, 1'b0);
		check({7'h0, pin_out[2]}, 8'h01, "buffer second");
		check({7'h0, pin_oe_n[3]}, 8'h01, "buffer odd off");
		$display("test compare done");
		wr(8'h10, 8'h04);
		set_pin(1'b1, 16'h1234);
		rd(8'h11);
		check(d, 8'h12, "capture rise");
		set_pin(1'b0, 16'h5678);
		set_pin(1'b1, 16'h5678);
		rd(8'h12);
		check(d, 8'h34, "capture held");
		wr(8'h10, 8'h08);
		set_pin(1'b0, 16'h9ABC);
		rd(8'h11);
		check(d, 8'h9A, "capture fall");
		rd(8'h12);
		wr(8'h10, 8'h0C);
		set_pin(1'b1, 16'h4321);
		rd(8'h11);
		check(d, 8'h43, "capture any");
		$display("test capture done");
		finish_test;
	end
endmodule // timer_channel_capture_compare_tb_top

// file: common/timer_channel_regs.vh
`ifndef TIMER_CHANNEL_REGS_VH
`define TIMER_CHANNEL_REGS_VH

// Register offsets, per channel (channel n at n*stride + offset)
`define CH_STRIDE         8'h04
`define OFF_MODE_CTRL     2'h0
`define OFF_VALUE_HIGH    2'h1
`define OFF_VALUE_LOW     2'h2
`define NUM_CHANNELS      6

// Mode/control field positions
`define BIT_FLAG          7
`define BIT_IRQ_EN        6
`define BIT_MSB           5
`define BIT_MSA           4
`define BIT_ELB           3
`define BIT_ELA           2
`define BIT_TOV           1
`define BIT_MAXD          0

`define CTRL_RESET        8'h00
`define EL_OFF            2'h0
`define EL_RISE_TOGGLE    2'h1
`define EL_FALL_CLEAR     2'h2
`define EL_ANY_SET        2'h3

`endif

// file: hdl/chan_pair_cmp.v
`timescale 1ns/10ps
`include "timer_channel_regs.vh"
// Capture edge detect and compare action for one channel
// Pin history is {current, previous}
module chan_pair_cmp (
	// Configuration
	input  wire [1:0] edge_level,
	input  wire       out_now,
	input  wire [1:0] pin_hist,
	// Result
	output reg        edge_hit,
	output reg        cmp_level
);
	always @* begin
		edge_hit  = 1'b0;
		cmp_level = out_now;
		case (edge_level)
			`EL_RISE_TOGGLE: begin
				edge_hit  = pin_hist == 2'h2;
				cmp_level = ~out_now;
			end
			`EL_FALL_CLEAR: begin
				edge_hit  = pin_hist == 2'h1;
				cmp_level = 1'b0;
			end
			`EL_ANY_SET: begin
				edge_hit  = pin_hist[0] ^ pin_hist[1];
				cmp_level = 1'b1;
			end
			default: begin
				edge_hit  = 1'b0;
				cmp_level = out_now;
			end
		endcase
	end
endmodule // chan_pair_cmp

// file: hdl/timer_channel_capture_compare.v
// Functional notes
// - Nonzero edge/level: select-A chooses capture (0) or unbuffered compare (1).
// - Edge/level 00: select-A 1 gives low initial level, 0 high.
// - Reset clears select-A of every channel.
// - Reset clears both edge/level bits of every channel.
// - Edge/level 00 releases pin to general-purpose port.
// - Edge/level 00 holds preset level; pin driven once a mode is enabled (code drives it in compare modes only).
// - Capture on rising (01), falling (10) or either edge (11).
// - Unbuffered compare match toggles (01), clears (10), sets (11).
// - Buffered compare match toggles, clears or sets likewise.
// - Toggle-on-overflow toggles compare output on overflow; no effect in capture.
// - Overflow action wins over simultaneous compare action.
// - Max-duty with toggle-on-overflow forces PWM to 100 percent.
// - Max-duty change takes effect in the next PWM cycle.
// - Each channel has read/write 16-bit value register, undefined after reset.
// - Capture: high byte read blocks captures until low byte read.
// - Compare: high byte write blocks compares and flag until low byte write.
// - Flag set by capture or match; writing 1 ignored; reset clears.
// - Flag cleared by read-while-set then write 0; new event cancels clear.
// - Select-B on even channel disables next odd channel and its pin.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "timer_channel_regs.vh"
module timer_channel_capture_compare (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// Timer counter
	input  wire [15:0] counter_value,
	input  wire        counter_overflow,
	// Channel pins
	input  wire [5:0]  timer_channel_pin_in,
	output reg  [5:0]  timer_channel_pin_out,
	output reg  [5:0]  timer_channel_pin_oe_n,
	// Channel status
	output reg  [5:0]  channel_irq
);
	reg  [7:0]  ctrl_r     [0:5];
	reg  [7:0]  val_hi_r   [0:5];
	reg  [7:0]  val_lo_r   [0:5];
	reg  [5:0]  out_r;
	reg  [5:0]  sync1_r;
	reg  [5:0]  sync2_r;
	reg  [5:0]  hist_r;
	reg  [5:0]  cap_block_r;
	reg  [5:0]  cmp_block_r;
	reg  [5:0]  flag_seen_r;
	reg  [5:0]  max_act_r;
	reg  [5:0]  buf_sel_r;
	reg  [7:0]  cap_lo_r   [0:5];
	wire [5:0]  edge_hit;
	wire [5:0]  cmp_level;
	wire [2:0]  sel_ch;
	wire [1:0]  sel_off;
	integer     i;

	function [2:0] chan_of;
		input [7:0] a;
		begin
			chan_of = a[4:2];
		end
	endfunction

	function is_disabled;
		input [2:0] ch;
		begin
			is_disabled = ch[0] & ctrl_r[ch - 3'h1][`BIT_MSB];
		end
	endfunction

	function [1:0] el_of;
		input [7:0] c;
		begin
			el_of = {c[`BIT_ELB], c[`BIT_ELA]};
		end
	endfunction

	assign sel_ch  = chan_of(reg_addr);
	assign sel_off = reg_addr[1:0];

	genvar g;
	generate
		for (g = 0; g < `NUM_CHANNELS; g = g + 1) begin : g_ch
			chan_pair_cmp chan_pair_cmp_inst (
				.edge_level (el_of(ctrl_r[g])),
				.out_now    (out_r[g]),
				.pin_hist   ({sync2_r[g], hist_r[g]}),
				.edge_hit   (edge_hit[g]),
				.cmp_level  (cmp_level[g])
			);
		end
	endgenerate

	// Per-channel compare match, using alternating buffer in paired mode
	function match_for;
		input [2:0] ch;
		input       sel;
		reg   [2:0] src;
		begin
			src = ch;
			if (!ch[0] && ctrl_r[ch][`BIT_MSB] && sel) begin
				src = ch + 3'h1;
			end
			match_for = counter_value == {val_hi_r[src], val_lo_r[src]};
		end
	endfunction

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < `NUM_CHANNELS; i = i + 1) begin
				ctrl_r[i]   <= `CTRL_RESET;
				val_hi_r[i] <= 8'h00;
				val_lo_r[i] <= 8'h00;
				cap_lo_r[i] <= 8'h00;
			end
			out_r                  <= 6'h00;
			sync1_r                <= 6'h00;
			sync2_r                <= 6'h00;
			hist_r                 <= 6'h00;
			cap_block_r            <= 6'h00;
			cmp_block_r            <= 6'h00;
			flag_seen_r            <= 6'h00;
			max_act_r              <= 6'h00;
			buf_sel_r              <= 6'h00;
			reg_rdata              <= 8'h00;
			timer_channel_pin_out  <= 6'h00;
			timer_channel_pin_oe_n <= 6'h3F;
			channel_irq            <= 6'h00;
		end else begin
			sync1_r <= timer_channel_pin_in;
			sync2_r <= sync1_r;
			hist_r  <= sync2_r;
			reg_rdata <= 8'h00;
			for (i = 0; i < `NUM_CHANNELS; i = i + 1) begin : ch_loop
				reg        active;
				reg        capture;
				reg        ev;
				reg        match;
				reg        sel_here;
				active   = el_of(ctrl_r[i]) != `EL_OFF && !is_disabled(i[2:0]);
				capture  = !ctrl_r[i][`BIT_MSB] && !ctrl_r[i][`BIT_MSA];
				sel_here = sel_ch == i[2:0];
				match    = match_for(i[2:0], buf_sel_r[i]);
				ev       = 1'b0;
				if (!active) begin
					out_r[i] <= ~ctrl_r[i][`BIT_MSA];
				end else if (capture) begin
					if (edge_hit[i] && !cap_block_r[i]) begin
						ev          = 1'b1;
						val_hi_r[i] <= counter_value[15:8];
						val_lo_r[i] <= counter_value[7:0];
					end
				end else begin
					if (counter_overflow) begin
						max_act_r[i] <= ctrl_r[i][`BIT_MAXD];
						if (ctrl_r[i][`BIT_MSB]) begin
							buf_sel_r[i] <= ~buf_sel_r[i];
						end
					end
					if (ctrl_r[i][`BIT_TOV] && max_act_r[i]) begin
						out_r[i] <= 1'b1;
					end else if (ctrl_r[i][`BIT_TOV] && counter_overflow) begin
						out_r[i] <= ~out_r[i];
					end else if (match && !cmp_block_r[i]) begin
						out_r[i] <= cmp_level[i];
					end
					if (match && !cmp_block_r[i]) begin
						ev = 1'b1;
					end
				end
				// Register access
				if (sel_here && reg_rd && !is_disabled(i[2:0])) begin
					case (sel_off)
						`OFF_MODE_CTRL: begin
							reg_rdata <= ctrl_r[i];
							if (ctrl_r[i][`BIT_FLAG]) begin
								flag_seen_r[i] <= 1'b1;
							end
						end
						`OFF_VALUE_HIGH: begin
							reg_rdata <= val_hi_r[i];
							if (capture) begin
								cap_block_r[i] <= 1'b1;
							end
						end
						`OFF_VALUE_LOW: begin
							reg_rdata      <= val_lo_r[i];
							cap_block_r[i] <= 1'b0;
						end
						default: reg_rdata <= 8'h00;
					endcase
				end
				if (sel_here && reg_wr && !is_disabled(i[2:0])) begin
					case (sel_off)
						`OFF_MODE_CTRL: begin
							ctrl_r[i][6:0] <= reg_wdata[6:0];
							if (i[0]) begin
								ctrl_r[i][`BIT_MSB] <= 1'b0;
							end
							if (!reg_wdata[`BIT_FLAG] && flag_seen_r[i] && !ev) begin
								ctrl_r[i][`BIT_FLAG] <= 1'b0;
							end
							flag_seen_r[i] <= 1'b0;
						end
						`OFF_VALUE_HIGH: begin
							val_hi_r[i] <= reg_wdata;
							if (!capture) begin
								cmp_block_r[i] <= 1'b1;
							end
						end
						`OFF_VALUE_LOW: begin
							val_lo_r[i]    <= reg_wdata;
							cmp_block_r[i] <= 1'b0;
						end
						default: ;
					endcase
				end
				if (ev) begin
					ctrl_r[i][`BIT_FLAG] <= 1'b1;
					flag_seen_r[i]       <= 1'b0;
				end
				// Capture channels only listen to the pin
				timer_channel_pin_oe_n[i] <= ~(active && !capture);
				timer_channel_pin_out[i]  <= out_r[i];
				channel_irq[i] <= ctrl_r[i][`BIT_FLAG] & ctrl_r[i][`BIT_IRQ_EN];
			end
		end
	end
endmodule // timer_channel_capture_compare
